//--- ssa_pkg.sv
// ssa_pkg.sv: constants and types for the management-bus slave front end.
// assumes a single 100 MHz clock domain and synchronous pin inputs.
package ssa_pkg;
	// -------------------------------------------------------------
	// slave addresses picked by the straps
	// -------------------------------------------------------------
	localparam logic [6:0] SSA_ADDR_DEFAULT = 7'h2e;	// 0101110
	localparam logic [6:0] SSA_ADDR_SEL_LO  = 7'h2c;	// 0101100
	localparam logic [6:0] SSA_ADDR_SEL_HI  = 7'h2d;	// 0101101
	// -------------------------------------------------------------
	// internal register map, local to this front end
	// -------------------------------------------------------------
	localparam logic [7:0] SSA_REG_CONFIG   = 8'h40;	// bit 1 selects alert pin role
	localparam logic [7:0] SSA_REG_STATUS   = 8'h41;
	localparam logic [7:0] SSA_REG_VID      = 8'h43;
	localparam logic [7:0] SSA_REG_MASK     = 8'h74;
	localparam logic [7:0] SSA_REG_OFS0     = 8'h70;
	localparam logic [7:0] SSA_REG_OFS1     = 8'h71;
	localparam logic [7:0] SSA_REG_OFS2     = 8'h72;
	localparam logic [7:0] SSA_REG_TEMP0    = 8'h25;
	localparam logic [7:0] SSA_REG_TEMP1    = 8'h26;
	localparam logic [7:0] SSA_REG_TEMP2    = 8'h27;
	localparam int         SSA_CFG_ALERT_BIT = 1;
	localparam logic [7:0] SSA_ZERO_BYTE    = 8'h00;
	localparam logic [3:0] SSA_BIT_LAST     = 4'h7;		// eighth bit index
	localparam logic [3:0] SSA_BIT_ZERO     = 4'h0;
	localparam int         SSA_NUM_TEMP     = 3;
	localparam logic [7:0] SSA_DIR_READ_MASK = 8'h01;

	// bus engine states, one-hot
	typedef enum logic [6:0] {
		SSA_IDLE   = 7'b0000001,
		SSA_ADDR   = 7'b0000010,
		SSA_AACK   = 7'b0000100,
		SSA_WBYTE  = 7'b0001000,
		SSA_WACK   = 7'b0010000,
		SSA_RBYTE  = 7'b0100000,
		SSA_RACK   = 7'b1000000
	} ssa_state_t;
endpackage

//--- ssa_slave.sv
// ssa_slave.sv: slave-side management bus front end with address straps,
// pointer, status/alert path, vid capture and temperature offsets.
// assumes scl/sda levels and straps arrive synchronous to CLOCK_IN.
//
// Function
// - 7-bit slave address; address-enable strap high gives 0101110.
// - address-enable strap low: select strap low 0101100, high 0101101.
// - address latched on first valid transaction; later strap changes ignored.
// - after assignment the straps serve fan drive output and tach input.
// - start is sda falling with scl high; device then expects address.
// - eight bits shifted in after start: address msb first, then direction.
// - on match, drive sda low in the low period before ninth clock.
// - on mismatch stay idle, sda released until next start.
// - direction 0 is master write, 1 is master read.
// - first write byte after address loads the register pointer.
// - limit comparison results kept in readable status bits.
// - alert pin role drives low while any unmasked status bit is set.
// - masks gate only the alert output, never the status bits.
// - five voltage-id inputs captured into a readable register.
// - signed offset added to each temperature reading before storing.
// - nine clocks per byte; sda changes only while scl is low.
// - writes are pointer or pointer plus data; reads return one byte.
`timescale 1ns/1ps
`default_nettype none
module ssa_slave (
	// clock and reset
	input  wire logic                CLOCK_IN,
	input  wire logic                SYS_RST_IN,
	// serial bus (open drain data, clock input only)
	input  wire logic                SCL_IN,
	input  wire logic                SDA_IN,
	output logic                     SDA_OUT,
	output logic                     SDA_OE_OUT,
	// address straps, sampled until the first valid transaction
	input  wire logic                ADDRESS_ENABLE_STRAP_IN,
	input  wire logic                ADDRESS_SELECT_STRAP_IN,
	// alternate pin roles once the address is fixed
	input  wire logic                THIRD_FAN_DRIVE_IN,
	output logic                     THIRD_FAN_DRIVE_OUT,
	output logic                     THIRD_FAN_DRIVE_OE_OUT,
	output logic                     FOURTH_FAN_SPEED_OUT,
	output logic                     ADDRESS_LOCKED_OUT,
	// alert pin (shared with a fan drive)
	input  wire logic                SECOND_FAN_DRIVE_IN,
	output logic                     ALERT_PIN_OUT,
	output logic                     ALERT_PIN_OE_OUT,
	// monitor side inputs
	input  wire logic [4:0]          CPU_VOLTAGE_ID_IN,
	input  wire logic [7:0]          LIMIT_FLAGS_IN,
	input  wire logic [ssa_pkg::SSA_NUM_TEMP-1:0] TEMP_VALID_IN,
	input  wire logic [7:0]          TEMP_RAW_IN [ssa_pkg::SSA_NUM_TEMP],
	// register write strobe towards the rest of the monitor
	output logic                     REG_WR_OUT,
	output logic [7:0]               REG_ADDR_OUT,
	output logic [7:0]               REG_WDATA_OUT
);
	import ssa_pkg::*;

	// -------------------------------------------------------------
	// bus edge detection
	// -------------------------------------------------------------
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, start_det, stop_det;
	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= SCL_IN;
			sda_q <= SDA_IN;
		end
	end
	assign scl_rise  = SCL_IN & ~scl_q;
	assign scl_fall  = ~SCL_IN & scl_q;
	assign start_det = scl_q & SCL_IN & sda_q & ~SDA_IN;
	assign stop_det  = scl_q & SCL_IN & ~sda_q & SDA_IN;

	// -------------------------------------------------------------
	// address strap selection and latch
	// -------------------------------------------------------------
	function automatic logic [6:0] strap_addr(input logic en, input logic sel);
		if (en)
			return SSA_ADDR_DEFAULT;
		return sel ? SSA_ADDR_SEL_HI : SSA_ADDR_SEL_LO;
	endfunction

	logic [6:0] addr_q, addr_d;
	logic       lock_q, lock_d;
	logic       addr_ok;
	// live straps until lock, so a strap settling after reset still counts
	always_comb begin
		addr_d = addr_q;
		lock_d = lock_q;
		if (!lock_q) begin
			addr_d = strap_addr(ADDRESS_ENABLE_STRAP_IN, ADDRESS_SELECT_STRAP_IN);
			if (addr_ok)
				lock_d = 1'b1;
		end
	end
	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			addr_q <= SSA_ADDR_DEFAULT;
			lock_q <= 1'b0;
		end else begin
			addr_q <= addr_d;
			lock_q <= lock_d;
		end
	end
	// straps hand over to fan roles once the address is fixed
	assign THIRD_FAN_DRIVE_OUT    = 1'b0;
	assign THIRD_FAN_DRIVE_OE_OUT = lock_q & ~THIRD_FAN_DRIVE_IN;
	assign FOURTH_FAN_SPEED_OUT   = lock_q & ADDRESS_SELECT_STRAP_IN;
	assign ADDRESS_LOCKED_OUT     = lock_q;

	// -------------------------------------------------------------
	// local registers: config, mask, offsets, status, vid, temps
	// -------------------------------------------------------------
	logic [7:0] cfg_q, mask_q, status_q, vid_q;
	logic [7:0] ofs_q [SSA_NUM_TEMP];
	logic [7:0] temp_q [SSA_NUM_TEMP];
	logic [7:0] ptr_q, ptr_d;
	logic       wr_hit, status_rd;

	// status bits set by hardware win over the clear-on-read
	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			cfg_q    <= SSA_ZERO_BYTE;
			mask_q   <= SSA_ZERO_BYTE;
			status_q <= SSA_ZERO_BYTE;
			vid_q    <= SSA_ZERO_BYTE;
		end else begin
			if (wr_hit && ptr_q == SSA_REG_CONFIG)
				cfg_q <= REG_WDATA_OUT;
			if (wr_hit && ptr_q == SSA_REG_MASK)
				mask_q <= REG_WDATA_OUT;
			status_q <= (status_rd ? SSA_ZERO_BYTE : status_q) | LIMIT_FLAGS_IN;
			vid_q    <= {3'b000, CPU_VOLTAGE_ID_IN};
		end
	end

	// offset registers and offset temperature results per channel
	genvar gi;
	for (gi = 0; gi < SSA_NUM_TEMP; gi++) begin : g_temp
		always_ff @(posedge CLOCK_IN) begin
			if (SYS_RST_IN) begin
				ofs_q[gi]  <= SSA_ZERO_BYTE;
				temp_q[gi] <= SSA_ZERO_BYTE;
			end else begin
				if (wr_hit && ptr_q == SSA_REG_OFS0 + 8'(gi))
					ofs_q[gi] <= REG_WDATA_OUT;
				if (TEMP_VALID_IN[gi])
					temp_q[gi] <= 8'(TEMP_RAW_IN[gi] + ofs_q[gi]);
			end
		end
	end

	// alert drives low while an unmasked status bit stands, if so configured
	logic alert_role;
	assign alert_role       = cfg_q[SSA_CFG_ALERT_BIT];
	assign ALERT_PIN_OUT    = 1'b0;
	assign ALERT_PIN_OE_OUT = alert_role ? |(status_q & ~mask_q)
				: ~SECOND_FAN_DRIVE_IN;

	// read mux over the pointer
	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		unique case (a)
			SSA_REG_CONFIG: return cfg_q;
			SSA_REG_STATUS: return status_q;
			SSA_REG_VID:    return vid_q;
			SSA_REG_MASK:   return mask_q;
			SSA_REG_OFS0:   return ofs_q[0];
			SSA_REG_OFS1:   return ofs_q[1];
			SSA_REG_OFS2:   return ofs_q[2];
			SSA_REG_TEMP0:  return temp_q[0];
			SSA_REG_TEMP1:  return temp_q[1];
			SSA_REG_TEMP2:  return temp_q[2];
			default:        return SSA_ZERO_BYTE;
		endcase
	endfunction

	// -------------------------------------------------------------
	// bus engine
	// -------------------------------------------------------------
	ssa_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic       rw_q, rw_d, first_q, first_d, oe_q, oe_d;
	logic [7:0] rd_byte;	// register picked by the pointer for a read
	logic [7:0] wd_q, wd_d;
	logic       wr_q, wr_d;

	assign addr_ok = (st_q == SSA_ADDR) && scl_fall && cnt_q == SSA_BIT_LAST + 4'h1
			&& sh_q[7:1] == addr_q;

	always_comb begin
		st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; rw_d = rw_q;
		first_d = first_q; oe_d = oe_q; ptr_d = ptr_q; wd_d = wd_q;
		wr_d = 1'b0;
		// a function result cannot be bit-selected, so hold it in a variable first
		rd_byte = rd_mux(ptr_q);
		if (start_det) begin
			st_d = SSA_ADDR;
			cnt_d = SSA_BIT_ZERO;
			oe_d = 1'b0;
		end else if (stop_det) begin
			st_d = SSA_IDLE;
			oe_d = 1'b0;
		end else unique case (st_q)
			SSA_IDLE: ;
			SSA_ADDR, SSA_WBYTE: begin
				if (scl_rise && cnt_q <= SSA_BIT_LAST) begin
					sh_d = {sh_q[6:0], SDA_IN};
					cnt_d = cnt_q + 4'h1;
				end
				if (scl_fall && cnt_q > SSA_BIT_LAST) begin
					cnt_d = SSA_BIT_ZERO;
					if (st_q == SSA_ADDR) begin
						if (sh_q[7:1] == addr_q) begin
							oe_d = 1'b1;
							rw_d = sh_q[0];
							first_d = 1'b1;
							st_d = SSA_AACK;
						end else
							st_d = SSA_IDLE;
					end else begin
						oe_d = 1'b1;
						st_d = SSA_WACK;
						if (first_q)
							ptr_d = sh_q;
						else begin
							wd_d = sh_q;
							wr_d = 1'b1;
						end
						first_d = 1'b0;
					end
				end
			end
			SSA_AACK, SSA_WACK: begin
				if (scl_fall) begin
					if (rw_q && st_q == SSA_AACK) begin
						sh_d = rd_byte;
						oe_d = ~rd_byte[7];
						cnt_d = SSA_BIT_ZERO;
						st_d = SSA_RBYTE;
					end else begin
						oe_d = 1'b0;
						st_d = SSA_WBYTE;
					end
				end
			end
			SSA_RBYTE: begin
				if (scl_fall) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == SSA_BIT_LAST) begin
						oe_d = 1'b0;	// master owns the ack slot
						st_d = SSA_RACK;
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						oe_d = ~sh_q[6];
					end
				end
			end
			SSA_RACK: begin
				// one byte per read: ack or no-ack alike, stay released after the slot
				if (scl_fall) begin
					oe_d = 1'b0;
					st_d = SSA_IDLE;
				end
			end
			default: st_d = SSA_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			st_q <= SSA_IDLE; cnt_q <= SSA_BIT_ZERO; sh_q <= SSA_ZERO_BYTE;
			rw_q <= 1'b0; first_q <= 1'b0; oe_q <= 1'b0; ptr_q <= SSA_ZERO_BYTE;
			wd_q <= SSA_ZERO_BYTE; wr_q <= 1'b0;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d;
			rw_q <= rw_d; first_q <= first_d; oe_q <= oe_d; ptr_q <= ptr_d;
			wd_q <= wd_d; wr_q <= wr_d;
		end
	end

	assign wr_hit        = wr_q;
	assign status_rd     = (st_q == SSA_RACK) && scl_fall && ptr_q == SSA_REG_STATUS;
	assign SDA_OUT       = 1'b0;
	assign SDA_OE_OUT    = oe_q;
	assign REG_WR_OUT    = wr_q;
	assign REG_ADDR_OUT  = ptr_q;
	assign REG_WDATA_OUT = wd_q;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	sequence s_addr_done;
		st_q == SSA_ADDR && scl_fall && cnt_q > SSA_BIT_LAST;
	endsequence
	a_ack_on_match: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		s_addr_done and sh_q[7:1] == addr_q && !start_det && !stop_det |=> SDA_OE_OUT)
		else $error("no ack on matching address");
	a_idle_mismatch: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		s_addr_done and sh_q[7:1] != addr_q && !start_det && !stop_det
		|=> !SDA_OE_OUT && st_q == SSA_IDLE)
		else $error("drove bus on foreign address");
	a_start_arms: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		start_det |=> st_q == SSA_ADDR && cnt_q == SSA_BIT_ZERO && !SDA_OE_OUT)
		else $error("start not taken");
	a_addr_stable: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		lock_q |=> $stable(addr_q))
		else $error("address changed after lock");
	a_default_addr: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		!lock_q && ADDRESS_ENABLE_STRAP_IN |=> addr_q == SSA_ADDR_DEFAULT)
		else $error("wrong default address");
	a_sda_scl_low: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		$changed(SDA_OE_OUT) && !$past(start_det) && !$past(stop_det) |-> !$past(SCL_IN))
		else $error("sda moved with scl high");
	a_status_sticky: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		|LIMIT_FLAGS_IN |=> (status_q & $past(LIMIT_FLAGS_IN)) == $past(LIMIT_FLAGS_IN))
		else $error("status bit lost");
	a_alert_low: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		alert_role && |(LIMIT_FLAGS_IN & ~mask_q) && !wr_hit |=> ALERT_PIN_OE_OUT)
		else $error("alert not driven");
	a_ptr_load: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		st_q == SSA_WBYTE && first_q && scl_fall && cnt_q > SSA_BIT_LAST
		&& !start_det && !stop_det |=> ptr_q == $past(sh_q))
		else $error("pointer not loaded");
endmodule // ssa_slave
`default_nettype wire

//--- ssa_host.sv
// ssa_host.sv: behavioural bus master that drives the serial clock and data.
// assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module ssa_host #(
	parameter int HALF = 4	// clock cycles per half bit period
) (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_oe_out
);
	// ------------------------------------------------------------
	// bus primitives
	// ------------------------------------------------------------
	// every change lands just after a rising edge of the system clock
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// start: data falls while the clock stays high
	task automatic start();
		sda_oe_out = 1'b1;
		tick(HALF);
		scl_out = 1'b0;
		tick(HALF);
	endtask
	// one clock pulse; data moves only while the clock is low
	task automatic bit_io(input logic b, output logic seen);
		sda_oe_out = ~b;
		tick(HALF);
		scl_out = 1'b1;
		tick(HALF);
		seen = sda_in;
		scl_out = 1'b0;
		tick(1);	// hold data one cycle past the fall so no stop is faked
	endtask
	// eight bits msb first, then the ninth acknowledge clock
	task automatic xbyte(input logic [7:0] d, input logic ack_bit,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ack_bit, ack);
	endtask
	// stop: data rises while the clock is high; the clock then stands still
	task automatic stop();
		sda_oe_out = 1'b1;
		tick(HALF);
		scl_out = 1'b1;
		tick(HALF);
		sda_oe_out = 1'b0;
		tick(2 * HALF);
	endtask
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
endmodule // ssa_host
`default_nettype wire

//--- tb_ssa_slave.sv
// tb_ssa_slave.sv: self-checking bench for the management-bus slave front end.
// assumes ssa_pkg, ssa_slave and the ssa_host master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_ssa_slave;
	import ssa_pkg::*;
	// ------------------------------------------------------------
	// signals, models and checks
	// ------------------------------------------------------------
	logic       clk = 1'b0;
	logic       rst, scl, host_oe, dut_oe, sda_o, sda, en_s, sel_s, fan3_in, fan3_o;
	logic       fan3_oe, tach_o, locked, fan2_in, alert_o, alert_oe, reg_wr, scl_q, oe_q;
	logic [4:0] vid;
	logic [7:0] flags, reg_a, reg_d, wr_a, wr_d;
	logic [2:0] tvalid;
	logic [7:0] traw [SSA_NUM_TEMP];
	int         failures = 0, total_checks = 0, wr_cnt = 0;
	always #5 clk = ~clk;
	assign sda = ~(host_oe | dut_oe);	// pull-up unless someone pulls low
	ssa_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));
	ssa_slave dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sda_o), .SDA_OE_OUT(dut_oe), .ADDRESS_ENABLE_STRAP_IN(en_s),
		.ADDRESS_SELECT_STRAP_IN(sel_s), .THIRD_FAN_DRIVE_IN(fan3_in),
		.THIRD_FAN_DRIVE_OUT(fan3_o), .THIRD_FAN_DRIVE_OE_OUT(fan3_oe),
		.FOURTH_FAN_SPEED_OUT(tach_o), .ADDRESS_LOCKED_OUT(locked),
		.SECOND_FAN_DRIVE_IN(fan2_in), .ALERT_PIN_OUT(alert_o), .ALERT_PIN_OE_OUT(alert_oe),
		.CPU_VOLTAGE_ID_IN(vid), .LIMIT_FLAGS_IN(flags), .TEMP_VALID_IN(tvalid),
		.TEMP_RAW_IN(traw), .REG_WR_OUT(reg_wr), .REG_ADDR_OUT(reg_a), .REG_WDATA_OUT(reg_d));
	task automatic chk(input string what, input logic [7:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// log write strobes; the slave must never move data while the clock is high
	always @(posedge clk) begin
		if (reg_wr === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			wr_a <= reg_a;
			wr_d <= reg_d;
		end
		if (scl === 1'b1 && scl_q === 1'b1 && dut_oe !== oe_q)
			chk("sda_move_scl_high", 8'h00, 8'h01);
		scl_q <= scl;
		oe_q <= dut_oe;
	end
	task automatic end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_reset(input logic en, sel);
		en_s = en;
		sel_s = sel;
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
		tick(2);	// bus may start two edges after release
	endtask
	// write: address, pointer, optional data; ak is high when the slave acked
	task automatic wr(input logic [6:0] a, input logic [7:0] p, d, input int n,
		output logic ak);
		logic [7:0] q;
		logic k;
		host.start();
		host.xbyte({a, 1'b0}, 1'b1, q, k);	// write direction
		ak = ~k;
		if (ak) host.xbyte(p, 1'b1, q, k);
		if (ak && n > 1) host.xbyte(d, 1'b1, q, k);
		host.stop();
	endtask
	// pointer-only write, then a one-byte read closed by no-acknowledge
	task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] q);
		logic k;
		wr(a, p, 8'h00, 1, k);
		host.start();
		host.xbyte({a, 1'b1}, 1'b1, q, k);	// read direction
		chk("read_ack", 8'h00, {7'h0, k});
		chk("sda_level", 8'h00, {7'h0, sda_o});
		host.xbyte(8'hff, 1'b1, q, k);
		host.stop();
		chk("sda_released", 8'h00, {7'h0, dut_oe});
	endtask
	task automatic s_straps();
		logic [6:0] ad [4] = '{SSA_ADDR_DEFAULT, SSA_ADDR_DEFAULT, SSA_ADDR_SEL_LO,
			SSA_ADDR_SEL_HI};
		logic ak;
		int n;
		for (int i = 0; i < 4; i++) begin
			do_reset(i < 2, i[0]);
			wr(ad[i] ^ 7'h01, SSA_REG_MASK, 8'h5a, 2, ak);
			chk("foreign_ack", 8'h00, {7'h0, ak});
			n = wr_cnt;
			wr(ad[i], SSA_REG_MASK, 8'h5a, 2, ak);
			chk("own_ack", 8'h01, {7'h0, ak});
			chk("wr_count", 8'h01, 8'(wr_cnt - n));
			chk("wr_addr", SSA_REG_MASK, wr_a);
			chk("wr_data", 8'h5a, wr_d);
			chk("locked", 8'h01, {7'h0, locked});
			en_s = ~en_s;
			sel_s = ~sel_s;
			fan3_in = 1'b0;
			wr(ad[i], SSA_REG_MASK, 8'h00, 2, ak);
			chk("kept_ack", 8'h01, {7'h0, ak});
			chk("tach_pass", {7'h0, sel_s}, {7'h0, tach_o});
			chk("fan3_drive", 8'h01, {7'h0, fan3_oe});
			chk("fan3_level", 8'h00, {7'h0, fan3_o});
			fan3_in = 1'b1;
		end
		do_reset(1'b1, 1'b0);
	endtask
	task automatic s_vid();
		logic [7:0] q;
		int n;
		n = wr_cnt;
		vid = 5'h15;
		rd(SSA_ADDR_DEFAULT, SSA_REG_VID, q);
		chk("ptr_only_writes", 8'h00, 8'(wr_cnt - n));
		chk("vid", 8'h15, q);
	endtask
	task automatic s_alert();
		logic [7:0] q;
		logic ak;
		// alert role off: the shared pin follows the fan drive request
		fan2_in = 1'b0;
		tick(1);
		chk("fan2_drive", 8'h01, {7'h0, alert_oe});
		chk("alert_level", 8'h00, {7'h0, alert_o});
		fan2_in = 1'b1;
		wr(SSA_ADDR_DEFAULT, SSA_REG_CONFIG, 8'h01 << SSA_CFG_ALERT_BIT, 2, ak);
		// alert role on: the fan drive request no longer reaches the pin
		fan2_in = 1'b0;
		tick(1);
		chk("fan2_ignored", 8'h00, {7'h0, alert_oe});
		fan2_in = 1'b1;
		for (int m = 0; m < 2; m++) begin
			wr(SSA_ADDR_DEFAULT, SSA_REG_MASK, m ? 8'h04 : 8'h00, 2, ak);
			flags = 8'h04;
			tick(1);
			flags = 8'h00;
			tick(2);
			chk("alert_drive", m ? 8'h00 : 8'h01, {7'h0, alert_oe});
			rd(SSA_ADDR_DEFAULT, SSA_REG_STATUS, q);
			chk("status", 8'h04, q);
			chk("alert_clear", 8'h00, {7'h0, alert_oe});
		end
	endtask
	task automatic s_offset();
		logic [7:0] ofs [3] = '{8'h05, 8'hfe, 8'h00};
		logic [7:0] q;
		logic ak;
		for (int c = 0; c < SSA_NUM_TEMP; c++) begin
			wr(SSA_ADDR_DEFAULT, SSA_REG_OFS0 + 8'(c), ofs[c], 2, ak);
			traw[c] = 8'h10 + 8'(c * 48);
			tvalid[c] = 1'b1;
			tick(1);
			tvalid[c] = 1'b0;
			tick(2);
			rd(SSA_ADDR_DEFAULT, SSA_REG_TEMP0 + 8'(c), q);
			chk("temp", traw[c] + ofs[c], q);
		end
	endtask
	// a hang counts as a mismatch and still reaches the closing report
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		$display("MISMATCH run_length expected finish seen timeout");
		end_sim();
	end
	initial begin
		rst = 1'b1;
		en_s = 1'b1;
		sel_s = 1'b0;
		fan3_in = 1'b1;
		fan2_in = 1'b1;
		vid = 5'h00;
		flags = 8'h00;
		tvalid = 3'h0;
		traw = '{default: 8'h00};
		s_straps();
		s_vid();
		s_alert();
		s_offset();
		end_sim();
	end
endmodule // tb_ssa_slave
`default_nettype wire
